// file: verilog/rps_map.vh
// register map, field layout and reset values of the register page stack
`ifndef RPS_MAP_VH
`define RPS_MAP_VH
`define RPS_ADDR_PAGE_SELECT 8'ha7
`define RPS_ADDR_PAGING_CONTROL 8'hcf
`define RPS_ADDR_STACK_READOUT 8'hd7
`define RPS_PAGE_CONTROL 8'h10
`define RPS_PAGE_SELECT_RESET 8'h00
`define RPS_IDX_MSB 6
`define RPS_IDX_LSB 4
`define RPS_IDX_RESET 3'h0
`define RPS_EN_BIT 0
`define RPS_EN_RESET 1'b1
`define RPS_LEVELS 5
`define RPS_LEVEL_RESET 8'h00
`endif

// file: verilog/rps_level_mux.v
// readout selector over the page stack levels
`include "rps_map.vh"
module rps_level_mux (
	// stack contents, level 0 in the low byte
	input wire [8*`RPS_LEVELS-1:0] levels,
	// selection
	input wire [2:0] index,
	// result
	output reg [7:0] value
);
	always @* begin
		value = 8'h00;
		if (index < 3'h5) begin
			value = levels[index*8 +: 8];
		end
	end
endmodule

// file: verilog/rps_register_page_stack.v
// register page stack with auto paging on interrupt entry and return
`include "rps_map.vh"
module rps_register_page_stack (
	// clock and reset
	input wire clk_sys,
	input wire rst_n,
	// register access from the core
	input wire [7:0] regAddr,
	input wire regWrite,
	input wire [7:0] regWdata,
	input wire regRead,
	output reg [7:0] regRdata,
	output reg regHit,
	// interrupt sequencing
	input wire irqEnter,
	input wire [7:0] irqPage,
	input wire irqReturn,
	// state view
	output reg [7:0] pageSelect,
	output reg autoPagingEnable
);
	// page moves, one per cycle: entry beats return beats a page write
	localparam [1:0] OP_HOLD = 2'b00;
	localparam [1:0] OP_PUSH = 2'b01;
	localparam [1:0] OP_POP = 2'b10;
	localparam [1:0] OP_WRITE = 2'b11;

	// current page and control fields
	reg [7:0] page_q;
	reg [7:0] page_d;
	reg [2:0] idx_q;
	reg en_q;
	wire en_d;
	wire [7:0] ctrlView;
	// move decode
	reg [1:0] op;
	wire pushReq;
	wire popReq;
	// register access decode
	wire onCtrlPage;
	wire selPage;
	wire selCtrl;
	wire selStack;
	wire wrPage;
	wire wrCtrl;
	// read path
	reg [7:0] rdData_d;
	reg rdHit_d;
	wire [7:0] stackValue;
	// level 0 is the live page, levels 1..4 hold saved pages
	wire [8*`RPS_LEVELS-1:0] stackFlat;
	genvar g;

	// control and readout exist only on the control page
	assign onCtrlPage = (page_q == `RPS_PAGE_CONTROL);
	assign selPage = (regAddr == `RPS_ADDR_PAGE_SELECT);
	assign selCtrl = onCtrlPage && (regAddr == `RPS_ADDR_PAGING_CONTROL);
	assign selStack = onCtrlPage && (regAddr == `RPS_ADDR_STACK_READOUT);
	assign wrPage = regWrite && selPage;
	assign wrCtrl = regWrite && selCtrl;
	assign pushReq = irqEnter && en_q;
	assign popReq = irqReturn && en_q;
	assign en_d = wrCtrl ? regWdata[`RPS_EN_BIT] : en_q;
	assign ctrlView = {1'b0, idx_q, 3'b000, en_q};
	assign stackFlat[7:0] = page_q;

	// entry and return together is a sequencer fault; entry is kept
	always @* begin
		if (pushReq) begin
			op = OP_PUSH;
		end else if (popReq) begin
			op = OP_POP;
		end else if (wrPage) begin
			op = OP_WRITE;
		end else begin
			op = OP_HOLD;
		end
	end

	// a page write in the cycle of an enabled entry or return is lost
	always @* begin
		case (op)
			OP_PUSH: begin
				page_d = irqPage;
			end
			OP_POP: begin
				page_d = stackFlat[15:8];
			end
			OP_WRITE: begin
				page_d = regWdata;
			end
			OP_HOLD: begin
				page_d = page_q;
			end
			default: begin
				page_d = page_q;
			end
		endcase
	end

	// all levels move on the same edge as the page, so the readout
	// never shows a half-shifted stack
	generate
		for (g = 1; g < `RPS_LEVELS; g = g + 1) begin : gLevel
			// the bottom level takes itself on a pop
			localparam integer UP = (g < `RPS_LEVELS - 1) ? g + 1 : g;
			localparam integer DOWN = g - 1;
			reg [7:0] level_q;
			reg [7:0] level_d;

			always @* begin
				case (op)
					OP_PUSH: begin
						level_d = stackFlat[DOWN*8 +: 8];
					end
					OP_POP: begin
						level_d = stackFlat[UP*8 +: 8];
					end
					OP_HOLD, OP_WRITE: begin
						level_d = level_q;
					end
					default: begin
						level_d = level_q;
					end
				endcase
			end

			always @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					level_q <= `RPS_LEVEL_RESET;
				end else begin
					level_q <= level_d;
				end
			end

			assign stackFlat[g*8 +: 8] = level_q;
		end
	endgenerate

	// readout selector over all five levels
	rps_level_mux uMux (
		.levels(stackFlat),
		.index(idx_q),
		.value(stackValue)
	);

	// the live page is level 0 of the stack
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			page_q <= `RPS_PAGE_SELECT_RESET;
		end else begin
			page_q <= page_d;
		end
	end

	// the index only steers the readout, it never moves the stack
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			idx_q <= `RPS_IDX_RESET;
		end else if (wrCtrl) begin
			idx_q <= regWdata[`RPS_IDX_MSB:`RPS_IDX_LSB];
		end
	end

	// a cleared enable already blocks an interrupt in the next cycle
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			en_q <= `RPS_EN_RESET;
		end else begin
			en_q <= en_d;
		end
	end

	// unmapped or absent reads give zero data and no hit
	always @* begin
		rdData_d = 8'h00;
		rdHit_d = 1'b0;
		if (regRead) begin
			if (selPage) begin
				rdData_d = page_q;
				rdHit_d = 1'b1;
			end else if (selCtrl) begin
				rdData_d = ctrlView;
				rdHit_d = 1'b1;
			end else if (selStack) begin
				rdData_d = stackValue;
				rdHit_d = 1'b1;
			end
		end
	end

	// data and hit stand together for one cycle after the read
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			regRdata <= 8'h00;
		end else begin
			regRdata <= rdData_d;
		end
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			regHit <= 1'b0;
		end else begin
			regHit <= rdHit_d;
		end
	end

	// outputs load the next state so they change with the registers
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pageSelect <= `RPS_PAGE_SELECT_RESET;
		end else begin
			pageSelect <= page_d;
		end
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			autoPagingEnable <= `RPS_EN_RESET;
		end else begin
			autoPagingEnable <= en_d;
		end
	end
endmodule

// file: tb/rps_core_model.sv
// core side model issuing interrupt entry and return pulses
module rps_core_model(input logic clk_sys,
	output logic irqEnter=0, irqReturn=0, output logic [7:0] irqPage=0);
timeunit 1ns; timeprecision 1ns;
task go(input logic e, input logic [7:0] p);
	irqEnter=e; irqReturn=!e; irqPage=p;
	@(posedge clk_sys); #1 irqEnter=0; irqReturn=0;
	@(posedge clk_sys); #1;
endtask
endmodule

// file: tb/rps_sva.sv
// assertions on the page stack ports
module rps_sva(input logic clk_sys, rst_n, regWrite, regRead, regHit,
	irqEnter, irqReturn, autoPagingEnable, input logic [7:0] regAddr,
	regWdata, regRdata, irqPage, pageSelect);
timeunit 1ns; timeprecision 1ns;
default clocking @(posedge clk_sys); endclocking
default disable iff (!rst_n);
wire en = autoPagingEnable;
sequence s_push; irqEnter && en; endsequence
sequence s_pop; irqReturn && !irqEnter && en; endsequence
sequence s_quiet; !regWrite && !irqEnter && !irqReturn; endsequence
a_entry_page: assert property (s_push |=> pageSelect==$past(irqPage))
	else $error("entry page");
a_ret_restore: assert property (s_push ##1 s_quiet ##1 s_pop
	|=> pageSelect==$past(pageSelect,3)) else $error("return page");
a_off_hold: assert property ((irqEnter||irqReturn) && !en && !regWrite
	|=> $stable(pageSelect)) else $error("disabled paging moved");
a_page_wr: assert property (regWrite && regAddr==8'ha7 &&
	!((irqEnter||irqReturn)&&en) |=> pageSelect==$past(regWdata))
	else $error("page write");
a_page_rd: assert property (regRead && regAddr==8'ha7
	|=> regHit && regRdata==$past(pageSelect)) else $error("page read");
a_ctl_rd: assert property (regRead && regAddr==8'hcf && pageSelect==8'h10
	|=> regRdata[0]==$past(en) && !regRdata[7]) else $error("ctl read");
a_rd_quiet: assert property (!regRead |=> !regHit && regRdata==8'h00)
	else $error("idle read data");
a_en_reset: assert property ($rose(rst_n) |-> en) else $error("reset enable");
endmodule
bind rps_register_page_stack rps_sva chk(.*);

// file: tb/testbench.sv
// self-checking bench for the register page stack
module testbench;
timeunit 1ns; timeprecision 1ns;
logic clk_sys=0, rst_n=0, regWrite=0, regRead=0, regHit, autoPagingEnable;
logic irqEnter, irqReturn;
logic [7:0] regAddr=0, regWdata=0, regRdata, pageSelect, irqPage;
logic [15:0] s=16'h3073;
int miscompares, num_checks, m[5], i, k;
always #4 clk_sys = ~clk_sys;
rps_register_page_stack DUT(.*);
rps_core_model core(.*);
function logic [15:0] nx(input logic [15:0] v);
	return {v[14:0], v[15]^v[13]^v[12]^v[10]};
endfunction
task chk(input string n, input logic [7:0] v, e);
	num_checks++;
	if (v !== e) begin
		miscompares++;
		$display("[ERR] %s exp %h seen %h", n, e, v);
	end
endtask
task wr(input logic [7:0] a, d);
	regAddr=a; regWdata=d; regWrite=1;
	@(posedge clk_sys); #1 regWrite=0;
	@(posedge clk_sys); #1;
endtask
task rd(input logic [7:0] a, e, input logic h);
	regAddr=a; regRead=1;
	@(posedge clk_sys); #1 regRead=0;
	chk("rdata", regRdata, e);
	chk("hit", regHit, 8'(h));
	@(posedge clk_sys); #1;
endtask
task results;
	$display("checks %0d errors %0d", num_checks, miscompares);
	if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
	else $display("TB: FAIL");
	$finish;
endtask
initial begin
	#50000 miscompares++;
	results;
end
initial begin
	repeat (12) @(posedge clk_sys);
	#1 rst_n = 1;
	rd(8'ha7, 8'h00, 1);
	wr(8'ha7, 8'h10);
	rd(8'hcf, 8'h01, 1);
	rd(8'h55, 8'h00, 0);
	$display("register test done");
	m[0] = 8'h10;
	for (i = 0; i < 6; i++) begin
		s = nx(s);
		core.go(1, s[7:0]);
		for (k = 4; k > 0; k--) m[k] = m[k-1];
		m[0] = s[7:0];
		chk("page", pageSelect, 8'(m[0]));
	end
	wr(8'ha7, 8'h10);
	m[0] = 8'h10;
	for (i = 0; i < 8; i++) begin
		wr(8'hcf, {1'b0, 3'(i), 4'h1});
		rd(8'hd7, i < 5 ? 8'(m[i]) : 8'h00, 1);
	end
	for (i = 0; i < 6; i++) begin
		core.go(0, 8'h00);
		for (k = 0; k < 4; k++) m[k] = m[k+1];
		chk("page", pageSelect, 8'(m[0]));
	end
	$display("stack test done");
	wr(8'ha7, 8'h10);
	wr(8'hcf, 8'h00);
	chk("enable", autoPagingEnable, 8'h00);
	for (i = 0; i < 2; i++) begin
		core.go(i[0], 8'h33);
		chk("page", pageSelect, 8'h10);
	end
	wr(8'hcf, 8'h01);
	chk("enable", autoPagingEnable, 8'h01);
	core.go(1, 8'h44);
	chk("page", pageSelect, 8'h44);
	core.go(0, 8'h00);
	chk("page", pageSelect, 8'h10);
	$display("enable test done");
	wr(8'hcf, 8'h00);
	rst_n = 0;
	repeat (2) @(posedge clk_sys);
	#1 rst_n = 1;
	chk("enable", autoPagingEnable, 8'h01);
	rd(8'ha7, 8'h00, 1);
	wr(8'ha7, 8'h10);
	rd(8'hcf, 8'h01, 1);
	$display("reset test done");
	results;
end
endmodule
